// ### core/dio_pkg.sv
package dio_pkg;
    localparam int NUM_CH      = 32;
    localparam int GROUP_W     = 8;
    localparam int NUM_GROUPS  = 4;
    localparam int FIFO_DEPTH  = 2048;
    localparam int PTR_W       = 11;
    localparam int CNT_W       = 12;
    localparam int SAMPLE_MHZ  = 200;
    localparam int CLOCK_NS    = 40;
    localparam int TICK_NS     = 5;
    localparam logic [31:0] TICKS_PER_CLK = 32'(CLOCK_NS / TICK_NS);
    localparam logic [CNT_W-1:0] FIFO_FULL_CNT = 12'h800;

    localparam logic [7:0] OFF_CTRL     = 8'h00;
    localparam logic [7:0] OFF_DIR      = 8'h04;
    localparam logic [7:0] OFF_VOLT     = 8'h08;
    localparam logic [7:0] OFF_IN       = 8'h0C;
    localparam logic [7:0] OFF_OUT      = 8'h10;
    localparam logic [7:0] OFF_OUT_SET  = 8'h14;
    localparam logic [7:0] OFF_OUT_CLR  = 8'h18;
    localparam logic [7:0] OFF_RISE     = 8'h1C;
    localparam logic [7:0] OFF_FALL     = 8'h20;
    localparam logic [7:0] OFF_LATCH_IN = 8'h24;
    localparam logic [7:0] OFF_LATCH_OUT= 8'h28;
    localparam logic [7:0] OFF_CMD      = 8'h2C;
    localparam logic [7:0] OFF_FIFO_TIME= 8'h30;
    localparam logic [7:0] OFF_FIFO_LVL = 8'h34;
    localparam logic [7:0] OFF_STATUS   = 8'h38;
    localparam logic [7:0] OFF_TIMER    = 8'h3C;

    localparam int CMD_LATCH   = 0;
    localparam int CMD_CLEAR   = 1;
    localparam int CMD_EVT_CLR = 2;

    localparam int ST_EMPTY    = 0;
    localparam int ST_FULL     = 1;
    localparam int ST_OVF      = 2;
    localparam int ST_EVT      = 3;
    localparam int ST_BOOT_LSB = 4;
    localparam int ST_CNT_LSB  = 16;

    localparam logic [7:0]  VOLT_MIN  = 8'h10;
    localparam logic [7:0]  VOLT_MAX  = 8'h2F;
    localparam logic [31:0] VOLT_RST  = 32'h21212121;
    localparam logic [3:0]  DIR_RST   = 4'h0;
    localparam logic [31:0] OUT_RST   = 32'h00000000;

    typedef struct packed {
        logic evt_en;
        logic out_run;
        logic out_mode;
        logic cap_en;
    } ctrl_s;

    typedef struct packed {
        logic [31:0] stamp;
        logic [31:0] level;
    } entry_s;

    typedef struct packed {
        logic        we;
        logic [31:0] mask;
        logic [31:0] data;
    } proc_req_s;

    typedef enum logic [1:0] {
        BOOT_CHECK = 2'b00,
        BOOT_LOAD  = 2'b01,
        BOOT_RUN   = 2'b10,
        BOOT_HALT  = 2'b11
    } boot_e;
endpackage : dio_pkg

// ### core/timestamped_dio_edge_fifo.sv
// The register addresses and the APB interface to the registers are this design's own decisions.
`timescale 1ns/1ps
`default_nettype none
module timestamped_dio_edge_fifo (
    input  wire logic                                  clock,
    input  wire logic                                  rstn,
    input  wire logic [7:0]                            paddr,
    input  wire logic                                  psel,
    input  wire logic                                  penable,
    input  wire logic                                  pwrite,
    input  wire logic [31:0]                           pwdata,
    output logic      [31:0]                           prdata,
    output logic                                       pready,
    output logic                                       pslverr,
    input  wire logic [dio_pkg::NUM_CH-1:0]            dio_in,
    output logic      [dio_pkg::NUM_CH-1:0]            dio_out,
    output logic      [dio_pkg::NUM_CH-1:0]            dio_oe_n,
    output logic      [dio_pkg::NUM_GROUPS-1:0][7:0]   group_voltage_select,
    input  wire logic                                  event_in,
    output logic                                       event_flag,
    input  wire logic                                  global_latch_sync,
    input  wire dio_pkg::proc_req_s                    proc_req,
    output logic      [dio_pkg::NUM_CH-1:0]            proc_in_levels,
    input  wire logic                                  boot_image_present,
    input  wire logic                                  boot_load_done,
    output logic                                       proc_load,
    output logic                                       proc_run
);
    import dio_pkg::*;

    // Pin synchroniser: 32 channels, event input, latch sync input.
    localparam int SYNC_W = NUM_CH + 2;
    logic [SYNC_W-1:0] s1_q, s2_q, s3_q, pins_q, pins_d;

    always_comb begin
        pins_d = pins_q;
        for (int i = 0; i < SYNC_W; i++) begin
            if (s2_q[i] == s3_q[i]) begin
                pins_d[i] = s3_q[i];
            end
        end
    end

    always_ff @(posedge clock or negedge rstn) begin
        if (!rstn) begin
            s1_q   <= '0;
            s2_q   <= '0;
            s3_q   <= '0;
            pins_q <= '0;
        end else begin
            s1_q   <= {global_latch_sync, event_in, dio_in};
            s2_q   <= s1_q;
            s3_q   <= s2_q;
            pins_q <= pins_d;
        end
    end

    logic [NUM_CH-1:0] lvl_new, lvl_q;
    logic              evt_lvl, evt_prev_q, sync_lvl, sync_prev_q;
    assign lvl_new  = pins_q[NUM_CH-1:0];
    assign evt_lvl  = pins_q[NUM_CH];
    assign sync_lvl = pins_q[NUM_CH+1];

    // Register state.
    ctrl_s             ctrl_q, ctrl_d;
    logic [3:0]        dir_q, dir_d;
    logic [31:0]       volt_q, volt_d;
    logic [31:0]       out_q, out_d;
    logic [31:0]       rise_q, rise_d, fall_q, fall_d;
    logic [31:0]       lat_in_q, lat_in_d, lat_out_q, lat_out_d;
    logic [31:0]       stage_q, stage_d;
    logic [31:0]       ts_q, ts_d;
    logic              evt_q, evt_d, ovf_q, ovf_d;
    logic              pready_q, pready_d, pslverr_q, pslverr_d;
    logic [31:0]       prdata_q, prdata_d;
    // Two-entry buffer between sources and the big FIFO.
    entry_s            buf_q [2];
    entry_s            buf_d [2];
    logic [1:0]        bcnt_q, bcnt_d;
    logic [PTR_W-1:0]  wr_q, wr_d, rd_q, rd_d;
    logic [CNT_W-1:0]  cnt_q, cnt_d;
    boot_e             boot_q, boot_d;
    entry_s            mem [FIFO_DEPTH];

    logic   act, stall, fifo_full, fifo_empty, buf_in_ready, buf_out_valid;
    logic   drain, cap_fire, cap_push, host_push, play_pop, host_pop, latch_fire;
    logic   due, clear, unmapped;
    entry_s head, push_entry;
    logic [31:0] rd_mux;

    assign fifo_full     = (cnt_q == FIFO_FULL_CNT);
    assign fifo_empty    = (cnt_q == '0);
    assign buf_in_ready  = (bcnt_q != 2'd2);
    assign buf_out_valid = (bcnt_q != 2'd0);
    assign head          = mem[rd_q];
    assign act           = psel & penable & pready_q;
    // A pattern write into a full buffer holds the bus rather than lose a word.
    assign stall = pwrite && (paddr == OFF_FIFO_LVL) && ctrl_q.out_mode && !buf_in_ready;
    assign clear = act && pwrite && (paddr == OFF_CMD) && pwdata[CMD_CLEAR];
    assign cap_fire = ctrl_q.cap_en && !ctrl_q.out_mode && (lvl_new != lvl_q);
    assign cap_push = cap_fire && buf_in_ready;
    assign host_push = act && pwrite && (paddr == OFF_FIFO_LVL) && ctrl_q.out_mode;
    assign drain = buf_out_valid && !fifo_full && !clear;
    // Signed distance keeps playback correct across stamp counter wrap.
    assign due = ($signed(ts_q - head.stamp) >= 0);
    assign play_pop = ctrl_q.out_mode && ctrl_q.out_run && !fifo_empty && due;
    assign host_pop = act && !pwrite && (paddr == OFF_FIFO_LVL) && !ctrl_q.out_mode && !fifo_empty;
    assign latch_fire = (act && pwrite && (paddr == OFF_CMD) && pwdata[CMD_LATCH])
                      || (sync_lvl && !sync_prev_q);
    assign push_entry = ctrl_q.out_mode ? entry_s'{stamp: stage_q, level: pwdata}
                                        : entry_s'{stamp: ts_q, level: lvl_new};

    always_comb begin
        unmapped = 1'b0;
        case (paddr)
            OFF_CTRL:      rd_mux = {28'h0000000, ctrl_q};
            OFF_DIR:       rd_mux = {28'h0000000, dir_q};
            OFF_VOLT:      rd_mux = volt_q;
            OFF_IN:        rd_mux = lvl_q;
            OFF_OUT:       rd_mux = out_q;
            OFF_OUT_SET:   rd_mux = out_q;
            OFF_OUT_CLR:   rd_mux = out_q;
            OFF_RISE:      rd_mux = rise_q;
            OFF_FALL:      rd_mux = fall_q;
            OFF_LATCH_IN:  rd_mux = lat_in_q;
            OFF_LATCH_OUT: rd_mux = lat_out_q;
            OFF_CMD:       rd_mux = 32'h00000000;
            OFF_FIFO_TIME: rd_mux = fifo_empty ? 32'h00000000 : head.stamp;
            OFF_FIFO_LVL:  rd_mux = fifo_empty ? 32'h00000000 : head.level;
            OFF_STATUS: begin
                rd_mux = 32'h00000000;
                rd_mux[ST_EMPTY] = fifo_empty;
                rd_mux[ST_FULL]  = fifo_full;
                rd_mux[ST_OVF]   = ovf_q;
                rd_mux[ST_EVT]   = evt_q;
                rd_mux[ST_BOOT_LSB +: 2] = boot_q;
                rd_mux[ST_CNT_LSB +: CNT_W] = cnt_q;
            end
            OFF_TIMER:     rd_mux = ts_q;
            default: begin
                rd_mux   = 32'h00000000;
                unmapped = 1'b1;
            end
        endcase
    end

    always_comb begin
        ctrl_d    = ctrl_q;
        dir_d     = dir_q;
        volt_d    = volt_q;
        out_d     = out_q;
        lat_in_d  = lat_in_q;
        lat_out_d = lat_out_q;
        stage_d   = stage_q;
        evt_d     = evt_q;
        ovf_d     = ovf_q;
        ts_d      = ts_q + TICKS_PER_CLK;
        pready_d  = psel && penable && !pready_q && !stall;
        pslverr_d = pready_d && unmapped;
        prdata_d  = pready_d ? rd_mux : prdata_q;
        rise_d    = rise_q;
        fall_d    = fall_q;
        if (act && pwrite) begin
            case (paddr)
                OFF_CTRL:      ctrl_d    = ctrl_s'(pwdata[3:0]);
                OFF_DIR:       dir_d     = pwdata[3:0];
                OFF_VOLT: begin
                    for (int g = 0; g < NUM_GROUPS; g++) begin
                        if (pwdata[g*8 +: 8] < VOLT_MIN) begin
                            volt_d[g*8 +: 8] = VOLT_MIN;
                        end else if (pwdata[g*8 +: 8] > VOLT_MAX) begin
                            volt_d[g*8 +: 8] = VOLT_MAX;
                        end else begin
                            volt_d[g*8 +: 8] = pwdata[g*8 +: 8];
                        end
                    end
                end
                OFF_OUT:       out_d     = pwdata;
                OFF_OUT_SET:   out_d     = out_q | pwdata;
                OFF_OUT_CLR:   out_d     = out_q & ~pwdata;
                OFF_RISE:      rise_d    = rise_q & ~pwdata;
                OFF_FALL:      fall_d    = fall_q & ~pwdata;
                OFF_LATCH_IN:  lat_in_d  = pwdata;
                OFF_LATCH_OUT: lat_out_d = pwdata;
                OFF_CMD: begin
                    if (pwdata[CMD_EVT_CLR]) begin
                        evt_d = 1'b0;
                    end
                    if (pwdata[CMD_CLEAR]) begin
                        ovf_d = 1'b0;
                    end
                end
                OFF_FIFO_TIME: stage_d   = pwdata;
                default: ;
            endcase
        end
        if (proc_req.we) begin
            out_d = (out_d & ~proc_req.mask) | (proc_req.data & proc_req.mask);
        end
        if (latch_fire) begin
            lat_in_d = lvl_q;
            out_d    = lat_out_q;
        end
        if (play_pop) begin
            out_d = head.level;
        end
        // Hardware sets win over software clears in the same cycle.
        rise_d = rise_d | (lvl_new & ~lvl_q);
        fall_d = fall_d | (~lvl_new & lvl_q);
        if (ctrl_q.evt_en && evt_lvl && !evt_prev_q) begin
            evt_d = 1'b1;
        end
        if (cap_fire && !buf_in_ready) begin
            ovf_d = 1'b1;
        end
    end

    always_comb begin
        buf_d  = buf_q;
        bcnt_d = bcnt_q;
        wr_d   = wr_q;
        rd_d   = rd_q;
        cnt_d  = cnt_q;
        if (clear) begin
            bcnt_d = 2'd0;
            wr_d   = '0;
            rd_d   = '0;
            cnt_d  = '0;
        end else begin
            if (drain) begin
                buf_d[0] = buf_q[1];
                wr_d     = wr_q + 1'b1;
            end
            if (cap_push || host_push) begin
                buf_d[(drain ? bcnt_q - 2'd1 : bcnt_q) == 2'd0 ? 0 : 1] = push_entry;
            end
            bcnt_d = bcnt_q + 2'((cap_push || host_push) ? 1 : 0) - 2'(drain ? 1 : 0);
            if (host_pop || play_pop) begin
                rd_d = rd_q + 1'b1;
            end
            cnt_d = cnt_q + CNT_W'(drain ? 1 : 0) - CNT_W'((host_pop || play_pop) ? 1 : 0);
        end
    end

    always_comb begin
        boot_d = boot_q;
        case (boot_q)
            BOOT_CHECK: boot_d = boot_image_present ? BOOT_LOAD : BOOT_HALT;
            BOOT_LOAD:  boot_d = boot_load_done ? BOOT_RUN : BOOT_LOAD;
            BOOT_RUN:   boot_d = BOOT_RUN;
            BOOT_HALT:  boot_d = BOOT_HALT;
            default:    boot_d = BOOT_CHECK;
        endcase
    end

    always_ff @(posedge clock) begin
        if (drain) begin
            mem[wr_q] <= buf_q[0];
        end
    end

    always_ff @(posedge clock or negedge rstn) begin
        if (!rstn) begin
            ctrl_q      <= '0;
            dir_q       <= DIR_RST;
            volt_q      <= VOLT_RST;
            out_q       <= OUT_RST;
            rise_q      <= '0;
            fall_q      <= '0;
            lat_in_q    <= '0;
            lat_out_q   <= '0;
            stage_q     <= '0;
            ts_q        <= '0;
            evt_q       <= 1'b0;
            ovf_q       <= 1'b0;
            pready_q    <= 1'b0;
            pslverr_q   <= 1'b0;
            prdata_q    <= '0;
            buf_q[0]    <= '0;
            buf_q[1]    <= '0;
            bcnt_q      <= 2'd0;
            wr_q        <= '0;
            rd_q        <= '0;
            cnt_q       <= '0;
            boot_q      <= BOOT_CHECK;
            lvl_q       <= '0;
            evt_prev_q  <= 1'b0;
            sync_prev_q <= 1'b0;
        end else begin
            ctrl_q      <= ctrl_d;
            dir_q       <= dir_d;
            volt_q      <= volt_d;
            out_q       <= out_d;
            rise_q      <= rise_d;
            fall_q      <= fall_d;
            lat_in_q    <= lat_in_d;
            lat_out_q   <= lat_out_d;
            stage_q     <= stage_d;
            ts_q        <= ts_d;
            evt_q       <= evt_d;
            ovf_q       <= ovf_d;
            pready_q    <= pready_d;
            pslverr_q   <= pslverr_d;
            prdata_q    <= prdata_d;
            buf_q       <= buf_d;
            bcnt_q      <= bcnt_d;
            wr_q        <= wr_d;
            rd_q        <= rd_d;
            cnt_q       <= cnt_d;
            boot_q      <= boot_d;
            lvl_q       <= lvl_new;
            evt_prev_q  <= evt_lvl;
            sync_prev_q <= sync_lvl;
        end
    end

    genvar g;
    generate
        for (g = 0; g < NUM_GROUPS; g++) begin : g_group
            assign dio_oe_n[g*GROUP_W +: GROUP_W] = {GROUP_W{~dir_q[g]}};
            assign group_voltage_select[g]         = volt_q[g*8 +: 8];
        end
    endgenerate

    assign dio_out        = out_q;
    assign prdata         = prdata_q;
    assign pready         = pready_q;
    assign pslverr        = pslverr_q;
    assign event_flag     = evt_q;
    assign proc_in_levels = lvl_q;
    assign proc_load      = (boot_q == BOOT_LOAD);
    assign proc_run       = (boot_q == BOOT_RUN);

    // Look-back checks wait for a sampled high reset, because the edge that releases
    // reset still finds every flop at its reset value.
    default clocking cb @(posedge clock);
    endclocking
    default disable iff (!rstn);

    dir_write_a: assert property (act && pwrite && paddr == OFF_DIR |=>
        dio_oe_n[7:0] == {8{~$past(pwdata[0])}} && dio_oe_n[31:24] == {8{~$past(pwdata[3])}})
        else $error("group direction does not follow the written value");
    stamp_step_a: assert property (rstn |=> ts_q == $past(ts_q) + TICKS_PER_CLK)
        else $error("stamp counter did not advance by the tick count");
    fifo_bound_a: assert property (cnt_q <= FIFO_FULL_CNT)
        else $error("FIFO count beyond its depth");
    rise_flag_a: assert property (lvl_new[0] && !lvl_q[0] |=> rise_q[0])
        else $error("rising edge not recorded");
    mode_excl_a: assert property (ctrl_q.out_mode && !host_push && !clear
        |=> bcnt_q <= $past(bcnt_q))
        else $error("capture pushed while in output mode");
    play_apply_a: assert property (play_pop |=> dio_out == $past(head.level))
        else $error("due pattern not applied");
    capture_push_a: assert property (cap_push && !drain && !clear |=> bcnt_q == $past(bcnt_q) + 2'd1)
        else $error("input change not buffered");
    latch_snap_a: assert property (latch_fire && !(act && pwrite && paddr == OFF_LATCH_IN)
        |=> lat_in_q == $past(lvl_q))
        else $error("latch did not snapshot inputs");
    apb_answer_a: assert property (psel && penable && !stall |-> ##[0:1] pready)
        else $error("register access not answered within one wait state");
    read_pop_a: assert property (host_pop && !drain |=> cnt_q == $past(cnt_q) - 12'h001)
        else $error("read entry not released");
    boot_load_a: assert property (rstn && boot_q == BOOT_CHECK && boot_image_present
        |=> proc_load)
        else $error("boot image present but not loaded");

    cap_seen_c:  cover property (cap_push ##[1:4] drain);
    play_seen_c: cover property (play_pop);
    full_seen_c: cover property (fifo_full);
    boot_run_c:  cover property (proc_run);
endmodule : timestamped_dio_edge_fifo
`default_nettype wire

// ### dv/host_bus_model.sv
`timescale 1ns/1ps
`default_nettype none
module host_bus_model (
    input  wire logic        clock,
    input  wire logic        pready,
    output logic      [7:0]  paddr,
    output logic             psel,
    output logic             penable,
    output logic             pwrite,
    output logic      [31:0] pwdata
);
    initial begin
        paddr   = 8'h00;
        psel    = 1'b0;
        penable = 1'b0;
        pwrite  = 1'b0;
        pwdata  = 32'h00000000;
    end

    // The request stands until pready is seen high; the data lines are then inverted,
    // so that the block cannot quietly lean on a released bus.
    task automatic xfer(input logic wr, input logic [7:0] addr, input logic [31:0] data);
        @(posedge clock);
        psel    <= 1'b1;
        penable <= 1'b0;
        paddr   <= addr;
        pwrite  <= wr;
        pwdata  <= data;
        @(posedge clock);
        penable <= 1'b1;
        do @(posedge clock); while (pready !== 1'b1);
        psel    <= 1'b0;
        penable <= 1'b0;
        pwdata  <= ~data;
    endtask : xfer
endmodule : host_bus_model
`default_nettype wire

// ### dv/timestamped_dio_edge_fifo_tb_top.sv
`timescale 1ns/1ps
`default_nettype none
module timestamped_dio_edge_fifo_tb_top;
    import dio_pkg::*;
    typedef struct packed {logic err; logic [31:0] mask; logic [31:0] exp;} note_s;
    logic                       clock, rstn, psel, penable, pwrite, pready, pslverr;
    logic                       event_in, event_flag, global_latch_sync, proc_load, proc_run;
    logic                       boot_image_present, boot_load_done;
    logic [7:0]                 paddr;
    logic [31:0]                pwdata, prdata, dio_in, dio_out, dio_oe_n, proc_in_levels;
    logic [31:0]                v1, lo, pat, t1;
    logic [NUM_GROUPS-1:0][7:0] group_voltage_select;
    proc_req_s                  proc_req;
    note_s                      notes[$];
    note_s                      n;
    int                         num_errors = 0;
    int                         tests_run = 0;

    timestamped_dio_edge_fifo uut (.clock(clock), .rstn(rstn), .paddr(paddr), .psel(psel),
        .penable(penable), .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .dio_in(dio_in), .dio_out(dio_out), .dio_oe_n(dio_oe_n),
        .group_voltage_select(group_voltage_select), .event_in(event_in),
        .event_flag(event_flag), .global_latch_sync(global_latch_sync), .proc_req(proc_req),
        .proc_in_levels(proc_in_levels), .boot_image_present(boot_image_present),
        .boot_load_done(boot_load_done), .proc_load(proc_load), .proc_run(proc_run));
    host_bus_model host (.clock(clock), .pready(pready), .paddr(paddr), .psel(psel),
        .penable(penable), .pwrite(pwrite), .pwdata(pwdata));

    initial begin
        clock = 1'b0;
        forever #20 clock = ~clock;
    end

    task automatic check(input logic [31:0] got, input logic [31:0] exp, input string what);
        tests_run++;
        if (got !== exp) begin
            num_errors++;
            $display("wrong value at %0t: %s got %h expected %h", $time, what, got, exp);
        end
    endtask : check

    task automatic tally_and_finish;
        $display("Checks made: %0d, mismatches: %0d", tests_run, num_errors);
        if (num_errors == 0 && tests_run > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask : tally_and_finish

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        notes.push_back('{1'b0, 32'h00000000, 32'h00000000});
        host.xfer(1'b1, a, d);
    endtask : wr

    task automatic rd(input logic [7:0] a, input logic [31:0] m, input logic [31:0] e,
                      input logic err = 1'b0);
        notes.push_back('{err, m, e});
        host.xfer(1'b0, a, 32'h00000000);
    endtask : rd

    task automatic cyc(input int k);
        repeat (k) @(posedge clock);
    endtask : cyc

    // Every completed transfer retires the oldest note, writes included.
    always @(posedge clock) begin
        if (rstn === 1'b1 && pready === 1'b1) begin
            n = notes.pop_front();
            check(prdata & n.mask, n.exp & n.mask, "read data");
            check({31'h0, pslverr}, {31'h0, n.err}, "slave error");
        end
    end

    initial begin
        repeat (20000) @(posedge clock);
        num_errors++;
        tally_and_finish();
    end

    initial begin
        void'($urandom(4107));
        rstn = 1'b0;
        dio_in = 32'h00000000;
        event_in = 1'b0;
        global_latch_sync = 1'b0;
        boot_image_present = 1'b1;
        boot_load_done = 1'b0;
        proc_req = '0;
        repeat (12) @(posedge clock);
        rstn <= 1'b1;
        cyc(3);
        check(dio_oe_n, 32'hFFFFFFFF, "power-up direction");
        check({31'h0, proc_load}, 32'h00000001, "boot load");
        boot_load_done <= 1'b1;
        rd(OFF_DIR, 32'h0000000F, 32'h00000000);
        rd(OFF_VOLT, 32'hFFFFFFFF, VOLT_RST);
        rd(OFF_STATUS, 32'h00000030, 32'h00000020);
        check({31'h0, proc_run}, 32'h00000001, "boot run");
        wr(OFF_DIR, 32'h00000005);
        cyc(2);
        check(dio_oe_n, 32'hFF00FF00, "group direction");
        wr(OFF_VOLT, 32'h05302F10);
        rd(OFF_VOLT, 32'hFFFFFFFF, 32'h102F2F10);
        check(group_voltage_select, 32'h102F2F10, "group voltage");
        v1 = $urandom() | 32'h00000001;
        wr(OFF_OUT, v1);
        rd(OFF_OUT, 32'hFFFFFFFF, v1);
        wr(OFF_OUT_SET, 32'h000000FF);
        wr(OFF_OUT_CLR, 32'hFF000000);
        rd(OFF_OUT_SET, 32'hFFFFFFFF, (v1 | 32'h000000FF) & 32'h00FFFFFF);
        check(dio_out, (v1 | 32'h000000FF) & 32'h00FFFFFF, "output pins");
        rd(8'h40, 32'hFFFFFFFF, 32'h00000000, 1'b1);
        wr(OFF_CTRL, 32'h00000001);
        dio_in <= v1;
        cyc(10);
        dio_in <= ~v1;
        cyc(10);
        rd(OFF_STATUS, 32'h0FFF0007, 32'h00020000);
        rd(OFF_FIFO_TIME, 32'h00000007, 32'h00000000);
        t1 = prdata;
        rd(OFF_FIFO_LVL, 32'hFFFFFFFF, v1);
        rd(OFF_FIFO_TIME, 32'h00000007, 32'h00000000);
        check(prdata - t1, 32'(10 * CLOCK_NS / TICK_NS), "stamp spacing");
        rd(OFF_FIFO_LVL, 32'hFFFFFFFF, ~v1);
        rd(OFF_TIMER, 32'h00000007, 32'h00000000);
        rd(OFF_STATUS, 32'h0FFF0007, 32'h00000001);
        rd(OFF_RISE, 32'hFFFFFFFF, 32'hFFFFFFFF);
        rd(OFF_FALL, 32'hFFFFFFFF, v1);
        wr(OFF_RISE, 32'hFFFFFFFF);
        rd(OFF_RISE, 32'hFFFFFFFF, 32'h00000000);
        dio_in <= v1;
        cyc(10);
        // Steady toggling fills the memory, then the buffer, then loses the last seven changes.
        repeat (2056) begin
            dio_in <= ~dio_in;
            cyc(3);
        end
        cyc(10);
        rd(OFF_STATUS, 32'h0FFF0007, {4'h0, FIFO_FULL_CNT, 16'h0006});
        wr(OFF_CMD, 32'h00000002);
        rd(OFF_STATUS, 32'h0FFF0007, 32'h00000001);
        wr(OFF_CTRL, 32'h00000000);
        lo = $urandom();
        wr(OFF_LATCH_OUT, lo);
        wr(OFF_CMD, 32'h00000001);
        rd(OFF_OUT, 32'hFFFFFFFF, lo);
        rd(OFF_LATCH_IN, 32'hFFFFFFFF, v1);
        rd(OFF_IN, 32'hFFFFFFFF, v1);
        wr(OFF_LATCH_OUT, ~lo);
        global_latch_sync <= 1'b1;
        cyc(6);
        global_latch_sync <= 1'b0;
        rd(OFF_OUT, 32'hFFFFFFFF, ~lo);
        pat = $urandom();
        proc_req <= '{we: 1'b1, mask: 32'hFFFF0000, data: pat};
        cyc(1);
        proc_req.we <= 1'b0;
        cyc(1);
        check(dio_out, (~lo & 32'h0000FFFF) | (pat & 32'hFFFF0000), "processor write");
        check(proc_in_levels, v1, "processor inputs");
        wr(OFF_CTRL, 32'h00000008);
        event_in <= 1'b1;
        cyc(6);
        check({31'h0, event_flag}, 32'h00000001, "event raised");
        wr(OFF_CMD, 32'h00000004);
        cyc(1);
        check({31'h0, event_flag}, 32'h00000000, "event cleared");
        // The second entry lies far in the future, so it must stay queued.
        wr(OFF_CTRL, 32'h00000002);
        wr(OFF_FIFO_TIME, 32'h00000000);
        wr(OFF_FIFO_LVL, pat);
        wr(OFF_FIFO_TIME, 32'h7FFFFFFF);
        wr(OFF_FIFO_LVL, ~pat);
        wr(OFF_CTRL, 32'h00000006);
        cyc(6);
        check(dio_out, pat, "timed pattern");
        cyc(2);
        tally_and_finish();
    end
endmodule : timestamped_dio_edge_fifo_tb_top
`default_nettype wire
